// ===== gsl_consts.svh
// constants of the gateway status led and id switch block
`ifndef GSL_CONSTS_SVH
`define GSL_CONSTS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define GSL_CLK_KHZ         10000
`define GSL_TICK_MS         250
`define GSL_TICK_CYC        (`GSL_TICK_MS * `GSL_CLK_KHZ)
`define GSL_WARN_S          60
`define GSL_WARN_TICKS      ((`GSL_WARN_S * 1000) / `GSL_TICK_MS)
`define GSL_SETTLE_CYC      16

// ----------------------------------------------------------------
// register offsets and switch codes
// ----------------------------------------------------------------
`define GSL_REG_STATUS      8'h00
`define GSL_REG_MASK        8'h04
`define GSL_REG_IDS         8'h08
`define GSL_REG_ERROR       8'h0C
`define GSL_ID_TEST         8'hEE
`define GSL_ID_CONFIG       8'hFF
`define GSL_ID_RESERVED     8'hDD
`define GSL_FB_ADDR_MAX     8'h7D
`define GSL_ERR_SERIOUS_MAX 4'h5
`define GSL_EVT_W           4
`define GSL_EVT_RST         4'h0
`define GSL_EVT_ERROR       0
`define GSL_EVT_WARN_END    1
`define GSL_EVT_BAD_ADDR    2
`define GSL_EVT_MODE        3

`endif

// ===== gsl_panel_model.sv
// rotary coding switch model of the front panel
`timescale 1ns/1ps
module gsl_panel_model (
    input  wire logic [7:0] serPos,
    input  wire logic [7:0] fbPos,
    output logic [3:0]      serHigh,
    output logic [3:0]      serLow,
    output logic [3:0]      fbHigh,
    output logic [3:0]      fbLow
);
    // a switch at rest shows its detent as a nibble; the first of a pair is the high one
    assign serHigh = serPos[7:4];
    assign serLow  = serPos[3:0];
    assign fbHigh  = fbPos[7:4];
    assign fbLow   = fbPos[3:0];
endmodule : gsl_panel_model

// ===== gsl_pkg.sv
// types of the gateway status led and id switch block
package gsl_pkg;

    typedef struct packed {
        logic active;    // data exchange running now
        logic ok;        // interface healthy
        logic ever;      // at least one exchange since power-up
    } gsl_ser_t;

    typedef struct packed {
        logic dataEx;
        logic waitComm;
        logic waitParam;
        logic busErr;
    } gsl_fb_t;

    typedef struct packed {
        logic       valid;   // one-cycle report
        logic       sys;     // system error class (fast flash)
        logic [3:0] code;
    } gsl_err_t;

    typedef struct packed {
        logic green;
        logic red;
    } gsl_led2_t;

    typedef enum logic [2:0] {
        GSL_SETTLE  = 3'b001,
        GSL_CAPTURE = 3'b010,
        GSL_RUN     = 3'b100
    } gsl_phase_t;

endpackage : gsl_pkg

// ===== gsl_prescaler.sv
// flash prescaler: tick every quarter second, fast and slow phases
`timescale 1ns/1ps
`include "gsl_consts.svh"
module gsl_prescaler #(
    parameter int TICK_CYC = `GSL_TICK_CYC
) (
    input  wire logic clock,
    input  wire logic sys_rst,
    output logic      tick,
    output logic      fastPhase,
    output logic      slowPhase
);
    localparam int CW = $clog2(TICK_CYC);
    logic [CW-1:0] count_q;

    generate
        if (TICK_CYC < 2) begin : g_bad
            $error("gsl_prescaler: TICK_CYC must be at least 2");
        end
    endgenerate

    // equal halves: each phase bit toggles on whole ticks
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            count_q <= '0;
            tick    <= 1'b0;
        end else if (count_q == CW'(TICK_CYC - 1)) begin
            count_q <= '0;
            tick    <= 1'b1;
        end else begin
            count_q <= count_q + 1'b1;
            tick    <= 1'b0;
        end
    end

    // 2 Hz from the tick toggle, 1 Hz from every second one
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            fastPhase <= 1'b0;
            slowPhase <= 1'b0;
        end else if (tick) begin
            fastPhase <= ~fastPhase;
            if (fastPhase) begin
                slowPhase <= ~slowPhase;
            end
        end
    end

endmodule : gsl_prescaler

// ===== gsl_status_panel.sv
// front-panel status leds and power-up id switch sampling
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "gsl_consts.svh"
module gsl_status_panel
    import gsl_pkg::*;
#(
    parameter int TICK_CYC   = `GSL_TICK_CYC,
    parameter int WARN_TICKS = `GSL_WARN_TICKS,
    parameter int SETTLE_CYC = `GSL_SETTLE_CYC
) (
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // engine state, same clock
    input  wire gsl_ser_t   serState,
    input  wire gsl_fb_t    fbState,
    input  wire gsl_err_t   errReport,
    // rotary switch pins, asynchronous
    input  wire logic [3:0] serial_id_high_switch,
    input  wire logic [3:0] serial_id_low_switch,
    input  wire logic [3:0] fbHighSwitch,
    input  wire logic [3:0] fbLowSwitch,
    // register port
    input  wire logic [7:0] regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic [31:0]     regRdData,
    output logic            irq,
    // panel
    output gsl_led2_t       serLed,
    output gsl_led2_t       fbLed,
    output logic            fbErrLed,
    output logic [3:0]      id_select_display,
    // sampled identities
    output logic [7:0]      serialNodeId,
    output logic [7:0]      fbStationAddr,
    output logic            nodeIdValid,
    output logic            fbAddrInvalid,
    output logic            testMode,
    output logic            configMode
);

    // ----------------------------------------------------------------
    // parameter checks
    // ----------------------------------------------------------------
    // refuse what the counters cannot hold
    generate
        if (WARN_TICKS < 1 || WARN_TICKS > 65535) begin : g_bad_warn
            $error("gsl_status_panel: WARN_TICKS out of range");
        end

        if (SETTLE_CYC < 1 || SETTLE_CYC > 255) begin : g_bad_settle
            $error("gsl_status_panel: SETTLE_CYC out of range");
        end

        if (TICK_CYC < 2) begin : g_bad_tick
            $error("gsl_status_panel: TICK_CYC too small");
        end
    endgenerate

    // ----------------------------------------------------------------
    // switch synchronisers and flash time base
    // ----------------------------------------------------------------
    logic [15:0] swSync;
    logic        tick;
    logic        fastPhase;
    logic        slowPhase;

    gsl_sync #(
        .W       (16)
    ) u_sync (
        .clock   (clock),
        .sys_rst (sys_rst),
        .pinIn   ({serial_id_high_switch, serial_id_low_switch,
                   fbHighSwitch, fbLowSwitch}),
        .syncOut (swSync)
    );

    gsl_prescaler #(
        .TICK_CYC  (TICK_CYC)
    ) u_presc (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .tick      (tick),
        .fastPhase (fastPhase),
        .slowPhase (slowPhase)
    );

    // ----------------------------------------------------------------
    // power-up sampling sequence
    // ----------------------------------------------------------------
    gsl_phase_t  phase_q;
    logic [7:0]  settle_q;
    logic        capture;

    // wait for the synchroniser to fill before taking the switches
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            phase_q  <= GSL_SETTLE;
            settle_q <= '0;
        end else begin
            unique case (phase_q)
                GSL_SETTLE: begin
                    settle_q <= settle_q + 1'b1;
                    if (settle_q == 8'(SETTLE_CYC - 1)) begin
                        phase_q <= GSL_CAPTURE;
                    end
                end
                GSL_CAPTURE: begin
                    phase_q <= GSL_RUN;
                end
                GSL_RUN: begin
                    phase_q <= GSL_RUN;         // no way back until reset
                end
                default: begin
                    phase_q <= GSL_SETTLE;
                end
            endcase
        end
    end

    // single-cycle capture strobe
    assign capture = (phase_q == GSL_CAPTURE);

    // serial id and its special codes, taken once
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            serialNodeId <= '0;
            testMode     <= 1'b0;
            configMode   <= 1'b0;
            nodeIdValid  <= 1'b0;
        end else if (capture) begin
            serialNodeId <= swSync[15:8];
            testMode     <= (swSync[15:8] == `GSL_ID_TEST);
            configMode   <= (swSync[15:8] == `GSL_ID_CONFIG);
            nodeIdValid  <= (swSync[15:8] != `GSL_ID_TEST) &&
                            (swSync[15:8] != `GSL_ID_CONFIG) &&
                            (swSync[15:8] != `GSL_ID_RESERVED);
        end
    end

    // fieldbus station address, later switch moves are ignored
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            fbStationAddr <= '0;
            fbAddrInvalid <= 1'b0;
        end else if (capture) begin
            fbStationAddr <= swSync[7:0];
            fbAddrInvalid <= (swSync[7:0] > `GSL_FB_ADDR_MAX);
        end
    end

    // ----------------------------------------------------------------
    // error latch and warning expiry
    // ----------------------------------------------------------------
    logic        errPending_q;
    logic        errSerious_q;
    logic        errSys_q;
    logic [3:0]  errCode_q;
    logic [15:0] warnCnt_q;
    logic        newErr;
    logic        warnEnd;

    // a serious error is never displaced; code zero means nothing
    assign newErr  = errReport.valid && (errReport.code != 4'h0) && !errSerious_q;
    assign warnEnd = errPending_q && !errSerious_q && !newErr && tick &&
                     (warnCnt_q == 16'(WARN_TICKS - 1));

    // hold the code until expiry or reset
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            errPending_q <= 1'b0;
            errSerious_q <= 1'b0;
            errSys_q     <= 1'b0;
            errCode_q    <= '0;
        end else if (newErr) begin
            errPending_q <= 1'b1;
            errSerious_q <= (errReport.code <= `GSL_ERR_SERIOUS_MAX);
            errSys_q     <= errReport.sys;
            errCode_q    <= errReport.code;
        end else if (warnEnd) begin
            errPending_q <= 1'b0;
            errCode_q    <= '0;
        end
    end

    // minute counter in quarter-second ticks, restarted by each warning
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            warnCnt_q <= '0;
        end else if (newErr || warnEnd) begin
            warnCnt_q <= '0;
        end else if (errPending_q && !errSerious_q && tick) begin
            warnCnt_q <= warnCnt_q + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // led drive
    // ----------------------------------------------------------------
    logic errPhase;

    // error class picks the rate
    assign errPhase = errSys_q ? fastPhase : slowPhase;

    // serial led: error first, then operating mode, then traffic
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            serLed <= '0;
        end else if (errPending_q) begin
            serLed <= '{green: 1'b0, red: 1'b1};
        end else if (testMode || configMode) begin
            serLed <= '{green: 1'b0, red: slowPhase};
        end else if (!serState.ever) begin
            serLed <= '{green: slowPhase, red: !slowPhase};
        end else if (serState.active) begin
            serLed <= '{green: 1'b1, red: 1'b0};
        end else begin
            serLed <= '{green: slowPhase && serState.ok, red: 1'b0};
        end
    end

    // error number leds blink the code while an error is pending and the serial led is steady red
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            id_select_display <= '0;
        end else begin
            id_select_display <= errPending_q ? (errCode_q & {4{errPhase}}) : 4'h0;
        end
    end

    // fieldbus state led, bus error wins over waiting states
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            fbLed <= '0;
        end else if (fbState.busErr) begin
            fbLed <= '{green: 1'b0, red: 1'b1};
        end else if (fbState.dataEx) begin
            fbLed <= '{green: 1'b1, red: 1'b0};
        end else if (fbState.waitParam) begin
            fbLed <= '{green: slowPhase, red: !slowPhase};
        end else if (fbState.waitComm) begin
            fbLed <= '{green: slowPhase, red: 1'b0};
        end else begin
            fbLed <= '0;
        end
    end

    // red error led goes dark only in data exchange
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            fbErrLed <= 1'b1;
        end else begin
            fbErrLed <= !fbState.dataEx;
        end
    end

    // ----------------------------------------------------------------
    // event status, mask and interrupt
    // ----------------------------------------------------------------
    logic [`GSL_EVT_W-1:0] status_q;
    logic [`GSL_EVT_W-1:0] mask_q;
    logic [`GSL_EVT_W-1:0] evt;
    logic [`GSL_EVT_W-1:0] w1c;
    logic                  modeSeen_q;
    logic [`GSL_EVT_W-1:0] statusNext;

    // address and mode events fire once, the cycle after capture
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            modeSeen_q <= 1'b0;
        end else begin
            modeSeen_q <= capture;
        end
    end

    // one-cycle event pulses
    always_comb begin
        evt                     = '0;
        evt[`GSL_EVT_ERROR]     = newErr;
        evt[`GSL_EVT_WARN_END]  = warnEnd;
        evt[`GSL_EVT_BAD_ADDR]  = modeSeen_q && fbAddrInvalid;
        evt[`GSL_EVT_MODE]      = modeSeen_q && (testMode || configMode);
    end

    // write-one-to-clear bits
    assign w1c = (regWr && regAddr == `GSL_REG_STATUS) ? regWrData[`GSL_EVT_W-1:0] : '0;

    // next status, shared with the interrupt
    assign statusNext = (status_q & ~w1c) | evt;

    // a new event in the clearing cycle survives the clear
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            status_q <= `GSL_EVT_RST;
        end else begin
            status_q <= statusNext;
        end
    end

    // interrupt mask, read/write
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            mask_q <= `GSL_EVT_RST;
        end else if (regWr && regAddr == `GSL_REG_MASK) begin
            mask_q <= regWrData[`GSL_EVT_W-1:0];
        end
    end

    // level interrupt, registered from the next status so it changes in the same cycle as the status
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(statusNext & mask_q);
        end
    end

    // ----------------------------------------------------------------
    // register read port, data in the cycle after the strobe
    // ----------------------------------------------------------------
    // high bits read as zero
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            regRdData <= '0;
        end else if (regRd) begin
            unique case (regAddr)
                `GSL_REG_STATUS: regRdData <= {28'h000_0000, status_q};
                `GSL_REG_MASK:   regRdData <= {28'h000_0000, mask_q};
                `GSL_REG_IDS:    regRdData <= {12'h000, nodeIdValid, fbAddrInvalid,
                                               configMode, testMode,
                                               fbStationAddr, serialNodeId};
                `GSL_REG_ERROR:  regRdData <= {24'h00_0000, 1'b0, errSerious_q,
                                               errSys_q, errPending_q, errCode_q};
                default:         regRdData <= 32'h0000_0000;  // unmapped reads zero
            endcase
        end else begin
            regRdData <= 32'h0000_0000;
        end
    end

endmodule : gsl_status_panel

// ===== gsl_status_panel_properties.sv
// concurrent checks on the ports of the status panel
`timescale 1ns/1ps
module gsl_status_panel_properties
    import gsl_pkg::*;
#(
    parameter int TICK_CYC   = 4,
    parameter int WARN_TICKS = 3,
    parameter int SETTLE_CYC = 16
) (
    input wire logic       clock,
    input wire logic       sys_rst,
    input wire gsl_ser_t   serState,
    input wire gsl_fb_t    fbState,
    input wire gsl_err_t   errReport,
    input wire gsl_led2_t  serLed,
    input wire gsl_led2_t  fbLed,
    input wire logic       fbErrLed,
    input wire logic [3:0] id_select_display,
    input wire logic [7:0] serialNodeId,
    input wire logic [7:0] fbStationAddr,
    input wire logic       nodeIdValid,
    input wire logic       fbAddrInvalid,
    input wire logic       testMode,
    input wire logic       configMode
);
    // --------
    // helpers
    // --------
    logic [5:0] upCnt_q;
    logic       badSeen_q;
    logic       anyErr_q;
    logic [3:0] badCode_q;
    wire        seriousEv = errReport.valid && errReport.code inside {[1:5]} && !badSeen_q;
    // identities are only judged once capture is surely over
    wire        idsUp = upCnt_q > 6'(SETTLE_CYC + 3);

    // cycles since reset, saturating so it never wraps back into capture
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) upCnt_q <= 6'h00;
        else if (upCnt_q != 6'h3F) upCnt_q <= upCnt_q + 6'h01;
    end

    // first serious code and any report; later serious codes are ignored
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            badSeen_q <= 1'b0;
            badCode_q <= 4'h0;
            anyErr_q  <= 1'b0;
        end else begin
            if (seriousEv) badSeen_q <= 1'b1;
            if (seriousEv) badCode_q <= errReport.code;
            if (errReport.valid && errReport.code != 4'h0) anyErr_q <= 1'b1;
        end
    end

    // --------
    // properties
    // --------
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence s_err_lit;
        serLed.red && !serLed.green;
    endsequence

    chk_fberr_off: assert property (fbState.dataEx ##1 fbState.dataEx |-> !fbErrLed)
        else $error("fieldbus error led lit in data exchange");
    chk_err_red: assert property (errReport.valid && errReport.code != 4'h0 |-> ##2 s_err_lit)
        else $error("serial led not red on error");
    chk_err_code: assert property (seriousEv |-> ##[2:12] (id_select_display == badCode_q))
        else $error("error number not shown");
    chk_ids_hold: assert property (idsUp |-> $stable({serialNodeId, fbStationAddr, testMode, configMode}))
        else $error("sampled identity changed");
    chk_addr_flag: assert property (idsUp |-> fbAddrInvalid == (fbStationAddr > 8'h7D))
        else $error("bad address flag wrong");
    chk_mode_codes: assert property (idsUp |-> (testMode == (serialNodeId == 8'hEE)) &&
        (configMode == (serialNodeId == 8'hFF)) && (nodeIdValid == !(serialNodeId inside {8'hDD, 8'hEE, 8'hFF})))
        else $error("mode decode wrong");
    chk_mode_red: assert property ($past(testMode || configMode) && (testMode || configMode) |-> !serLed.green)
        else $error("green lit in test or config mode");
    chk_active_green: assert property ((!anyErr_q && !testMode && !configMode && serState.active && serState.ever) [*2]
        |-> serLed.green && !serLed.red)
        else $error("serial led not steady green");
    chk_fb_red: assert property (fbState.busErr [*2] |-> fbLed.red && !fbLed.green)
        else $error("fieldbus led not red on bus error");
endmodule : gsl_status_panel_properties

// ===== gsl_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module gsl_sync #(
    parameter int W = 4
) (
    input  wire logic         clock,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] pinIn,
    output logic [W-1:0]      syncOut
);
    logic [W-1:0] stage1_q;
    logic [W-1:0] stage2_q;
    logic [W-1:0] stage3_q;

    // first stage feeds only the second one
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            stage1_q <= '0;
            stage2_q <= '0;
            stage3_q <= '0;
        end else begin
            stage1_q <= pinIn;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            syncOut <= '0;
        end else if (stage2_q == stage3_q) begin
            syncOut <= stage3_q;
        end
    end

endmodule : gsl_sync

// ===== tb_gateway_status_led_and_id_switch.sv
// self-checking bench of the status panel
`timescale 1ns/1ps
`define CHECK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
    $display("Error at %0t: got %h want %h", $time, a, b); end end
module tb_gateway_status_led_and_id_switch;
    import gsl_pkg::*;
    localparam int TICK = 4;
    localparam int WARN = 12;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    gsl_ser_t    serState = '0;
    gsl_fb_t     fbState = '0;
    gsl_err_t    errReport = '0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0000_0000;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [7:0]  serPos = 8'h3C;
    logic [7:0]  fbPos = 8'h12;
    logic [3:0]  sHi, sLo, fHi, fLo, disp, dispOr;
    logic [31:0] regRdData, rd;
    logic [7:0]  serialNodeId, fbStationAddr;
    logic        irq, fbErrLed, nodeIdValid, fbAddrInvalid, testMode, configMode;
    gsl_led2_t   serLed, fbLed;
    int          err_count = 0;
    int          n_compared = 0;
    int          dispChg;
    int          serCnt [4];
    int          fbCnt [4];

    // --------
    // design and panel
    // --------
    gsl_panel_model PANEL (.serPos(serPos), .fbPos(fbPos), .serHigh(sHi), .serLow(sLo), .fbHigh(fHi), .fbLow(fLo));
    gsl_status_panel #(.TICK_CYC(TICK), .WARN_TICKS(WARN), .SETTLE_CYC(16)) DUT (.clock(clock), .sys_rst(sys_rst),
        .serState(serState), .fbState(fbState), .errReport(errReport), .serial_id_high_switch(sHi),
        .serial_id_low_switch(sLo), .fbHighSwitch(fHi), .fbLowSwitch(fLo), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irq(irq), .serLed(serLed), .fbLed(fbLed),
        .fbErrLed(fbErrLed), .id_select_display(disp), .serialNodeId(serialNodeId), .fbStationAddr(fbStationAddr),
        .nodeIdValid(nodeIdValid), .fbAddrInvalid(fbAddrInvalid), .testMode(testMode), .configMode(configMode));

    // 10 MHz clock
    initial begin
        forever #50 clock = ~clock;
    end

    // --------
    // tasks
    // --------
    task automatic close_out;
        $display("compared %0d, errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        regAddr <= a; regWrData <= d; regWr <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
    endtask : reg_wr

    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        regAddr <= a; regRd <= 1'b1;
        @(posedge clock);
        regRd <= 1'b0;
        #1 d = regRdData;
        @(posedge clock);
    endtask : reg_rd

    task automatic report(input logic [3:0] c, input logic s);
        @(posedge clock);
        errReport <= '{valid: 1'b1, sys: s, code: c};
        @(posedge clock);
        errReport <= '0;
    endtask : report

    // switches are set before reset and held through capture
    task automatic do_reset(input logic [7:0] s, input logic [7:0] f);
        @(posedge clock);
        serPos <= s; fbPos <= f; sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (20) @(posedge clock);
    endtask : do_reset

    // tallies led colour pairs and error number flashing over 32 cycles
    task automatic watch;
        logic prev;
        serCnt = '{0, 0, 0, 0}; fbCnt = '{0, 0, 0, 0}; dispChg = 0; dispOr = 4'h0;
        repeat (3) @(posedge clock);
        #1 prev = |disp;
        repeat (32) begin
            @(posedge clock);
            #1 serCnt[{serLed.green, serLed.red}]++;
            fbCnt[{fbLed.green, fbLed.red}]++;
            if ((|disp) != prev) dispChg++;
            prev = |disp;
            dispOr = dispOr | disp;
        end
        @(posedge clock);
    endtask : watch

    // bit 0 off, 1 red, 2 green, 3 both, set where that pair was seen
    function automatic logic [3:0] mask(input int c [4]);
        for (int i = 0; i < 4; i++) mask[i] = (c[i] != 0);
    endfunction : mask

    task automatic t_ids;
        logic [7:0]  sw [4] = '{8'h3C, 8'hDD, 8'hEE, 8'hFF};
        logic [7:0]  fw [4] = '{8'h12, 8'h7D, 8'h7E, 8'h00};
        logic [31:0] e;
        for (int i = 0; i < 4; i++) begin
            do_reset(sw[i], fw[i]);
            e = {12'h000, !(sw[i] inside {8'hDD, 8'hEE, 8'hFF}), fw[i] > 8'h7D, sw[i] == 8'hFF, sw[i] == 8'hEE,
                fw[i], sw[i]};
            reg_rd(8'h08, rd);
            `CHECK(rd, e)
            reg_rd(8'h00, rd);
            `CHECK(rd[3:2], {e[17] | e[16], e[18]})
            serPos <= ~sw[i]; fbPos <= ~fw[i];
            watch;
            `CHECK(mask(serCnt), (i > 1) ? 4'b0011 : 4'b0110)
            `CHECK({serialNodeId, fbStationAddr}, {sw[i], fw[i]})
        end
    endtask : t_ids

    task automatic t_serial;
        gsl_ser_t   st [3] = '{3'b111, 3'b011, 3'b001};
        logic [3:0] ex [3] = '{4'b0100, 4'b0101, 4'b0001};
        do_reset(8'h3C, 8'h12);
        for (int i = 0; i < 3; i++) begin
            serState <= st[i];
            watch;
            `CHECK(mask(serCnt), ex[i])
        end
    endtask : t_serial

    task automatic t_fb;
        gsl_fb_t    st [5] = '{4'b0001, 4'b1000, 4'b0010, 4'b0100, 4'b0000};
        logic [3:0] ex [5] = '{4'b0010, 4'b0100, 4'b0110, 4'b0101, 4'b0001};
        for (int i = 0; i < 5; i++) begin
            fbState <= st[i];
            watch;
            `CHECK(mask(fbCnt), ex[i])
            `CHECK(fbErrLed, !st[i].dataEx)
        end
    endtask : t_fb

    task automatic t_errors;
        do_reset(8'h3C, 8'h12);
        reg_wr(8'h04, 32'h0000_0001);
        report(4'h7, 1'b0);
        watch;
        `CHECK({mask(serCnt), dispOr, 4'(dispChg)}, {4'b0010, 4'h7, 4'h4})
        `CHECK(irq, 1'b1)
        reg_wr(8'h04, 32'h0000_0000);
        repeat (2) @(posedge clock);
        `CHECK(irq, 1'b0)
        reg_wr(8'h04, 32'h0000_0002);
        repeat (20) @(posedge clock);
        `CHECK({irq, serLed.red}, 2'b10)
        reg_rd(8'h00, rd);
        `CHECK(rd, 32'h0000_0003)
        reg_wr(8'h00, 32'h0000_0003);
        reg_rd(8'h00, rd);
        `CHECK({irq, rd}, {1'b0, 32'h0000_0000})
        report(4'h3, 1'b1);
        watch;
        `CHECK({mask(serCnt), dispOr, 4'(dispChg)}, {4'b0010, 4'h3, 4'h8})
        report(4'h9, 1'b0);
        repeat (60) @(posedge clock);
        reg_rd(8'h0C, rd);
        `CHECK(rd, 32'h0000_0073)
        reg_rd(8'h10, rd);
        `CHECK(rd, 32'h0000_0000)
        reg_wr(8'h08, 32'hFFFF_FFFF);
        reg_rd(8'h08, rd);
        `CHECK(rd, 32'h0008_123C)
    endtask : t_errors

    // --------
    // main sequence and watchdog
    // --------
    initial begin
        t_ids;
        t_serial;
        t_fb;
        t_errors;
        close_out;
    end

    // the whole run needs well under 3000 cycles
    initial begin
        #500_000;
        err_count++;
        close_out;
    end
endmodule : tb_gateway_status_led_and_id_switch

bind gsl_status_panel gsl_status_panel_properties #(.TICK_CYC(TICK_CYC), .WARN_TICKS(WARN_TICKS),
    .SETTLE_CYC(SETTLE_CYC)) u_props (.clock(clock), .sys_rst(sys_rst), .serState(serState), .fbState(fbState),
    .errReport(errReport), .serLed(serLed), .fbLed(fbLed), .fbErrLed(fbErrLed),
    .id_select_display(id_select_display), .serialNodeId(serialNodeId), .fbStationAddr(fbStationAddr),
    .nodeIdValid(nodeIdValid), .fbAddrInvalid(fbAddrInvalid), .testMode(testMode), .configMode(configMode));
